/* File: rtl/ucc_pkg.sv */
// constants, types and register map of the uwb channel control block
// assumes a single 25 MHz clock domain and an axi4-lite register master
//
// Overview of operation
// (RQ1) pulse-rate code 01 selects 16 MHz, 10 selects 64 MHz; others reserved.
// (RQ2) transmitter sends the standard delimiter when both delimiter enables clear.
// (RQ3) transmit custom enable set: transmitted delimiter follows user pattern.
// (RQ4) receiver hunts the standard delimiter when both delimiter enables clear.
// (RQ5) receive custom enable set: receiver searches for the user pattern.
// (RQ6) software matches receive delimiter pattern to the far transmitter's.
// (RQ7) five-bit transmit preamble code field selects transmitter preamble code.
// (RQ8) separate five-bit receive preamble code field, independent of transmit.
// (RQ9) software picks preamble codes recommended for channel and pulse rate.
// (RQ10) software never writes the reserved register file at index 0x20.
// (RQ11) vendor delimiter enable overrides both custom delimiter enables.
package ucc_pkg;

  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;

  // printed offsets are register indices; byte address is four times these
  localparam logic [IDX_W-1:0] IDX_CHAN_CTRL = 6'h1F;
  localparam logic [IDX_W-1:0] IDX_RESERVED = 6'h20;
  localparam logic [IDX_W-1:0] IDX_USER_DELIM = 6'h21;
  localparam logic [IDX_W-1:0] IDX_DELIM_CTRL = 6'h22;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h23;

  // channel control field positions
  localparam int LOW_CFG_W = 18;
  localparam int PRF_LSB = 18;
  localparam int TX_CUSTOM_BIT = 20;
  localparam int RX_CUSTOM_BIT = 21;
  localparam int TX_CODE_LSB = 22;
  localparam int RX_CODE_LSB = 27;
  localparam int CODE_W = 5;
  localparam logic [1:0] PRF_CODE_16M = 2'h1;
  localparam logic [1:0] PRF_CODE_64M = 2'h2;

  // user delimiter word: tx magnitude, tx sign, rx magnitude, rx sign
  localparam int PATTERN_W = 16;
  localparam int TX_PATTERN_LSB = 0;
  localparam int RX_PATTERN_LSB = 16;

  // delimiter control and status bit positions
  localparam int VENDOR_EN_BIT = 0;
  localparam int ST_PRF_BAD_BIT = 0;
  localparam int ST_TX_MODE_LSB = 1;
  localparam int ST_RX_MODE_LSB = 3;
  localparam int ST_RESV_WR_BIT = 5;

  // values after reset
  localparam logic [31:0] CHAN_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] USER_DELIM_RST = 32'h0000_0000;
  localparam logic VENDOR_EN_RST = 1'b0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DELIM_STANDARD,
    DELIM_USER,
    DELIM_VENDOR
  } ucc_delim_mode_t;

  typedef enum logic [1:0] {
    PRF_NONE,
    PRF_16M,
    PRF_64M
  } ucc_prf_t;

  typedef struct packed {
    ucc_delim_mode_t tx_delim_mode;
    ucc_delim_mode_t rx_delim_mode;
    logic [PATTERN_W-1:0] tx_pattern;
    logic [PATTERN_W-1:0] rx_pattern;
    ucc_prf_t rx_prf;
    logic [CODE_W-1:0] tx_code;
    logic [CODE_W-1:0] rx_code;
    logic [LOW_CFG_W-1:0] low_cfg;
  } ucc_phy_cfg_t;

  localparam ucc_phy_cfg_t PHY_CFG_RST = '0;

endpackage

/* File: rtl/ucc_delim_sel.sv */
// delimiter source selection for one direction (tx or rx)
// assumes both enables are steady register bits
`timescale 1ns/100ps

module ucc_delim_sel (
  // enables
  input wire logic custom_en,
  input wire logic vendor_en,
  // chosen delimiter source
  output ucc_pkg::ucc_delim_mode_t mode
);
  import ucc_pkg::*;

  always_comb begin
    if (vendor_en) begin
      mode = DELIM_VENDOR; // see RQ11
    end else if (custom_en) begin
      mode = DELIM_USER; // see RQ3 see RQ5
    end else begin
      mode = DELIM_STANDARD; // see RQ2 see RQ4
    end
  end

endmodule

/* File: rtl/ucc_top.sv */
// channel control register bank of a uwb transceiver with axi4-lite slave
// assumes an axi4-lite master on CLK_SYS; PHY_CFG feeds the radio datapath
`timescale 1ns/100ps

module ucc_top (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // axi4-lite write address
  input wire logic [ucc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // axi4-lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read address
  input wire logic [ucc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // axi4-lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // radio configuration
  output ucc_pkg::ucc_phy_cfg_t PHY_CFG
);
  import ucc_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [IDX_W-1:0] addr_idx(logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  function automatic logic [31:0] merge_strb(logic [31:0] old_word,
                                             logic [31:0] data,
                                             logic [3:0] strb);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic ucc_prf_t prf_decode(logic [1:0] code);
    ucc_prf_t res;
    res = PRF_NONE; // reserved codes select no rate
    if (code == PRF_CODE_16M) begin
      res = PRF_16M;
    end else if (code == PRF_CODE_64M) begin
      res = PRF_64M;
    end
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // register state

  logic [31:0] chan_ctrl;
  logic [31:0] user_delim;
  logic vendor_en;
  logic resv_wr_seen;

  logic aw_held;
  logic [IDX_W-1:0] aw_idx;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  logic [31:0] rd_word;
  logic rd_ok;

  ucc_delim_mode_t tx_mode;
  ucc_delim_mode_t rx_mode;
  ucc_prf_t rx_prf;
  ucc_phy_cfg_t next_phy_cfg;
  logic [31:0] status_word;

  //////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order

  // no new address or data while a response is still pending
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
  assign do_write = aw_held && w_held;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      aw_held <= 1'b0;
      aw_idx <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'b1;
      aw_idx <= addr_idx(S_AXI_AWADDR);
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      unique case (aw_idx)
        IDX_CHAN_CTRL, IDX_RESERVED, IDX_USER_DELIM, IDX_DELIM_CTRL,
        IDX_STATUS: begin
          S_AXI_BRESP <= RESP_OKAY;
        end
        default: begin
          S_AXI_BRESP <= RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration registers

  // pulse rate, custom delimiter enables and preamble codes in one word
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      chan_ctrl <= CHAN_CTRL_RST;
    end else if (do_write && aw_idx == IDX_CHAN_CTRL) begin
      chan_ctrl <= merge_strb(chan_ctrl, w_data, w_strb); // see RQ7 see RQ8
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      user_delim <= USER_DELIM_RST;
    end else if (do_write && aw_idx == IDX_USER_DELIM) begin
      user_delim <= merge_strb(user_delim, w_data, w_strb);
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      vendor_en <= VENDOR_EN_RST;
    end else if (do_write && aw_idx == IDX_DELIM_CTRL && w_strb[0]) begin
      vendor_en <= w_data[VENDOR_EN_BIT];
    end
  end

  // the reserved file holds nothing; a write is dropped but remembered,
  // since software that touches it is misbehaving
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      resv_wr_seen <= 1'b0;
    end else if (do_write && aw_idx == IDX_RESERVED) begin
      resv_wr_seen <= 1'b1; // see RQ10
    end else if (do_write && aw_idx == IDX_STATUS && w_strb[0]
                 && w_data[ST_RESV_WR_BIT]) begin
      resv_wr_seen <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // delimiter source and pulse-rate decode

  ucc_delim_sel u_tx_delim (
    .custom_en(chan_ctrl[TX_CUSTOM_BIT]),
    .vendor_en(vendor_en),
    .mode(tx_mode)
  );

  ucc_delim_sel u_rx_delim (
    .custom_en(chan_ctrl[RX_CUSTOM_BIT]),
    .vendor_en(vendor_en),
    .mode(rx_mode)
  );

  assign rx_prf = prf_decode(chan_ctrl[PRF_LSB +: 2]); // see RQ1

  always_comb begin
    next_phy_cfg = PHY_CFG_RST;
    next_phy_cfg.tx_delim_mode = tx_mode; // see RQ2 see RQ3 see RQ11
    next_phy_cfg.rx_delim_mode = rx_mode; // see RQ4 see RQ5 see RQ11
    // patterns pass whatever the mode; the datapath uses them only in user
    next_phy_cfg.tx_pattern = user_delim[TX_PATTERN_LSB +: PATTERN_W];
    next_phy_cfg.rx_pattern = user_delim[RX_PATTERN_LSB +: PATTERN_W];
    next_phy_cfg.rx_prf = rx_prf;
    next_phy_cfg.tx_code = chan_ctrl[TX_CODE_LSB +: CODE_W]; // see RQ7
    next_phy_cfg.rx_code = chan_ctrl[RX_CODE_LSB +: CODE_W]; // see RQ8
    next_phy_cfg.low_cfg = chan_ctrl[LOW_CFG_W-1:0];
  end

  // registered so the radio sees a clean word one cycle after a write
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PHY_CFG <= PHY_CFG_RST;
    end else begin
      PHY_CFG <= next_phy_cfg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read channel

  always_comb begin
    status_word = '0;
    status_word[ST_PRF_BAD_BIT] = (rx_prf == PRF_NONE);
    status_word[ST_TX_MODE_LSB +: 2] = tx_mode;
    status_word[ST_RX_MODE_LSB +: 2] = rx_mode;
    status_word[ST_RESV_WR_BIT] = resv_wr_seen;
  end

  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    unique case (addr_idx(S_AXI_ARADDR))
      IDX_CHAN_CTRL: begin
        rd_word = chan_ctrl;
      end
      IDX_RESERVED: begin
        rd_word = '0;
      end
      IDX_USER_DELIM: begin
        rd_word = user_delim;
      end
      IDX_DELIM_CTRL: begin
        rd_word[VENDOR_EN_BIT] = vendor_en;
      end
      IDX_STATUS: begin
        rd_word = status_word;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_word;
      S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule

/* File: tb/ucc_properties.sv */
// port assertions for the channel control register bank
// assumes one clock domain and the axi4-lite timing of ucc_top
`timescale 1ns/100ps

module ucc_checker (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // write channels
  input wire logic [ucc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // read channels
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  // radio side
  input wire ucc_pkg::ucc_phy_cfg_t PHY_CFG
);
  import ucc_pkg::*;
  logic wr_both;
  logic wr_cc;
  logic vend;
  // only full-word writes are tracked, partial ones merge old bytes
  assign wr_both = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
    && S_AXI_WREADY;
  assign wr_cc = wr_both && S_AXI_AWADDR == 8'h7C && S_AXI_WSTRB == 4'hF;
  // vendor enable as last written, so the mode checks cannot pass blindly
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      vend <= 1'h0;
    end else if (wr_both && S_AXI_AWADDR == 8'h88 && S_AXI_WSTRB[0]) begin
      vend <= S_AXI_WDATA[0];
    end
  end
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  //////////////////////////////////////////////////////////////////////
  chk_write_answer: assert property (wr_both |=> ##1 S_AXI_BVALID)
    else $error("write not answered");
  chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    |=> S_AXI_RVALID) else $error("read not answered");
  chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp dropped");
  chk_prf_decode: assert property (wr_cc |-> ##3 PHY_CFG.rx_prf ==
    ($past(S_AXI_WDATA[19:18], 3) == 2'h1 ? PRF_16M :
    $past(S_AXI_WDATA[19:18], 3) == 2'h2 ? PRF_64M : PRF_NONE))
    else $error("pulse rate wrong");
  chk_tx_code: assert property (wr_cc |-> ##3
    PHY_CFG.tx_code == $past(S_AXI_WDATA[26:22], 3))
    else $error("tx code wrong");
  chk_rx_code: assert property (wr_cc |-> ##3
    PHY_CFG.rx_code == $past(S_AXI_WDATA[31:27], 3))
    else $error("rx code wrong");
  chk_tx_delim_mode: assert property (wr_cc |-> ##3
    PHY_CFG.tx_delim_mode == (vend ? DELIM_VENDOR :
    ($past(S_AXI_WDATA[20], 3) ? DELIM_USER : DELIM_STANDARD)))
    else $error("tx delimiter wrong");
  chk_rx_delim_mode: assert property (wr_cc |-> ##3
    PHY_CFG.rx_delim_mode == (vend ? DELIM_VENDOR :
    ($past(S_AXI_WDATA[21], 3) ? DELIM_USER : DELIM_STANDARD)))
    else $error("rx delimiter wrong");
endmodule

bind ucc_top ucc_checker ucc_checker_inst (.CLK_SYS, .RST, .S_AXI_AWADDR,
  .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
  .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
  .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .PHY_CFG);

/* File: tb/tb_top.sv */
// self-checking bench for ucc_top driven as an axi4-lite master
// assumes the design files and ucc_checker are compiled before it
`timescale 1ns/100ps

module tb_top;
  import ucc_pkg::*;
  logic CLK_SYS = 1'h0;
  logic RST = 1'h1;
  logic [7:0] S_AXI_AWADDR = 8'h00;
  logic [7:0] S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0] S_AXI_WSTRB = 4'h0;
  logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
  logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA, d, udw, lf = 32'hD375B9D5;
  ucc_phy_cfg_t PHY_CFG;
  logic [34:0] note_q[$];
  logic ven = 1'h0, seen = 1'h0;
  int bad_count = 0, checks_done = 0, i;

  ucc_top ucc_top_inst (.CLK_SYS, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .PHY_CFG);

  always #20 CLK_SYS = ~CLK_SYS;
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // vendor enable wins over either custom bit
  function automatic ucc_delim_mode_t mode(input logic c);
    return ven ? DELIM_VENDOR : (c ? DELIM_USER : DELIM_STANDARD);
  endfunction

  function automatic logic [31:0] stat(input logic [31:0] v);
    return {26'h0, seen, mode(v[21]), mode(v[20]),
      v[19:18] != 2'h1 && v[19:18] != 2'h2};
  endfunction

  task automatic final_report();
    // let the monitor take the answer of the last transfer first
    @(negedge CLK_SYS);
    if (note_q.size() != 0) bad_count++;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic take(input logic [34:0] got);
    logic [34:0] e;
    e = note_q.size() > 0 ? note_q.pop_front() : 'x;
    checks_done++;
    if (got !== e) begin
      bad_count++;
      $display("wrong value %0t: got %h want %h", $time, got, e);
    end
  endtask

  // write data is not part of a write answer, so zero stands in for it
  always @(posedge CLK_SYS) begin
    if (S_AXI_BVALID && S_AXI_BREADY) take({1'h0, S_AXI_BRESP, 32'h0});
    if (S_AXI_RVALID && S_AXI_RREADY) take({1'h1, S_AXI_RRESP, S_AXI_RDATA});
  end
  //////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    input logic [3:0] s, input logic [1:0] r);
    int n;
    logic done;
    @(posedge CLK_SYS);
    note_q.push_back({1'h0, r, 32'h0});
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_WSTRB <= s;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    done = 1'h0;
    for (n = 0; n < 50 && !done; n++) begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
      if (S_AXI_BVALID) begin
        done = 1'h1;
        S_AXI_BREADY <= 1'h0;
      end
    end
    if (!done) bad_count++;
    if (!done) final_report();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v,
    input logic [1:0] r);
    int n;
    logic done;
    @(posedge CLK_SYS);
    note_q.push_back({1'h1, r, v});
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    done = 1'h0;
    for (n = 0; n < 50 && !done; n++) begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
      if (S_AXI_RVALID) begin
        done = 1'h1;
        S_AXI_RREADY <= 1'h0;
      end
    end
    if (!done) bad_count++;
    if (!done) final_report();
  endtask

  task automatic cfg_chk(input logic [31:0] v);
    ucc_phy_cfg_t e;
    e.tx_delim_mode = mode(v[20]);
    e.rx_delim_mode = mode(v[21]);
    e.tx_pattern = udw[15:0];
    e.rx_pattern = udw[31:16];
    e.rx_prf = v[19:18] == PRF_CODE_16M ? PRF_16M :
      (v[19:18] == PRF_CODE_64M ? PRF_64M : PRF_NONE);
    e.tx_code = v[26:22];
    e.rx_code = v[31:27];
    e.low_cfg = v[17:0];
    checks_done++;
    if (PHY_CFG !== e) begin
      bad_count++;
      $display("wrong value %0t: radio cfg %h", $time, PHY_CFG);
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge CLK_SYS);
    RST <= 1'h0;
    rd(8'h7C, CHAN_CTRL_RST, RESP_OKAY);
    lf = next_rand(lf);
    udw = lf;
    wr(8'h84, udw, 4'hF, RESP_OKAY);
    rd(8'h84, udw, RESP_OKAY);
    for (i = 0; i < 8; i++) begin
      lf = next_rand(lf);
      d = lf;
      d[21:18] = {i[1:0], i[1:0]};
      ven = i[2];
      wr(8'h88, {31'h0, ven}, 4'hF, RESP_OKAY);
      rd(8'h88, {31'h0, ven}, RESP_OKAY);
      wr(8'h7C, d, 4'hF, RESP_OKAY);
      rd(8'h7C, d, RESP_OKAY);
      rd(8'h8C, stat(d), RESP_OKAY);
      cfg_chk(d);
    end
    wr(8'h7C, ~d, 4'h4, RESP_OKAY);
    d[23:16] = ~d[23:16];
    rd(8'h7C, d, RESP_OKAY);
    cfg_chk(d);
    wr(8'h80, lf, 4'hF, RESP_OKAY);
    seen = 1'h1;
    rd(8'h80, 32'h0, RESP_OKAY);
    rd(8'h8C, stat(d), RESP_OKAY);
    wr(8'h8C, 32'h20, 4'hF, RESP_OKAY);
    seen = 1'h0;
    rd(8'h8C, stat(d), RESP_OKAY);
    wr(8'hFC, lf, 4'hF, RESP_SLVERR);
    rd(8'hFC, 32'h0, RESP_SLVERR);
    rd(8'h7C, d, RESP_OKAY);
    @(posedge CLK_SYS);
    RST <= 1'h1;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'h0;
    {d, udw, ven} = '0;
    rd(8'h7C, 32'h0, RESP_OKAY);
    cfg_chk(d);
    final_report();
  end
endmodule
